// File: hdl/pwr_seq_pkg.sv
// Purpose: Shared constants and types for the power, reset and boot sequencer
// Assumes: 200 MHz sys_clk
// Notes:   Strap vectors are ordered {strap2, strap1, strap0}, 1 = floating

`default_nettype none

package pwr_seq_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int     CLK_MHZ       = 200;
    localparam int     SETTLE_US     = 10;
    localparam int     SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
    localparam int     SETTLE_W      = 12;
    localparam int     HOLD_S        = 5;
    localparam longint HOLD_CYCLES_L = longint'(HOLD_S) * CLK_MHZ * 1000000;
    localparam int     HOLD_W        = 30;

    // ****************************************
    // Synchroniser bit map
    // ****************************************
    localparam int         SYNC_W     = 8;
    localparam int         IDX_FAULT  = 0;
    localparam int         IDX_EXTRST = 1;
    localparam int         IDX_BUTTON = 2;
    localparam int         IDX_RECOV  = 3;
    localparam int         IDX_STRAP  = 4;
    localparam int         IDX_RAIL   = 7;
    localparam logic [7:0] SYNC_RST   = 8'h7e;

    // ****************************************
    // Strap codes, 0 = grounded
    // ****************************************
    localparam logic [2:0] STRAP_FUSE = 3'h7;
    localparam logic [2:0] STRAP_SPI  = 3'h1;
    localparam logic [2:0] STRAP_SD   = 3'h4;
    localparam logic [2:0] STRAP_EMMC = 3'h5;
    localparam logic [2:0] STRAP_DL   = 3'h6;

    typedef enum logic [2:0] {
        BOOT_FUSE = 3'h0,
        BOOT_SPI  = 3'h1,
        BOOT_SD   = 3'h2,
        BOOT_EMMC = 3'h3,
        BOOT_DL   = 3'h4
    } boot_src_t;

    typedef enum logic [2:0] {
        ST_OFF        = 3'h0,
        ST_CARRIER_UP = 3'h1,
        ST_RUN        = 3'h2,
        ST_SUSPEND    = 3'h3,
        ST_HALT       = 3'h4
    } state_t;

    // Strap decode, unlisted patterns fall back to the fuse default
    function automatic boot_src_t strap_decode(input logic [2:0] s);
        boot_src_t r;
        r = BOOT_FUSE;
        case (s)
            STRAP_SPI:  r = BOOT_SPI;
            STRAP_SD:   r = BOOT_SD;
            STRAP_EMMC: r = BOOT_EMMC;
            STRAP_DL:   r = BOOT_DL;
            default:    r = BOOT_FUSE;
        endcase
        return r;
    endfunction

endpackage

`default_nettype wire

// File: hdl/carrier_pins_if.sv
// Purpose: Carries raw carrier inputs to the synchroniser and synced copies back
// Assumes: One clock domain on the synced side
// Notes:   Bit map given by the IDX_ constants

`timescale 1ns/1ps
`default_nettype none

interface carrier_pins_if;
    logic [7:0] raw;
    logic [7:0] synced;

    modport sync_side (
        input  raw,
        output synced
    );
    modport user (
        output raw,
        input  synced
    );
endinterface

`default_nettype wire

// File: hdl/pin_sync.sv
// Purpose: Two-flop synchroniser bank for the asynchronous carrier inputs
// Assumes: Inputs may change at any time relative to sys_clk
// Notes:   Reset values put the sequencer in its safe, unpowered view

`timescale 1ns/1ps
`default_nettype none

module pin_sync (
    input wire logic       sys_clk,
    input wire logic       rst,
    carrier_pins_if.sync_side pins
);

    // ****************************************
    // Synchroniser stages
    // ****************************************
    logic [7:0] meta_r;
    logic [7:0] sync_r;

    // One pair of flops per input bit
    for (genvar i = 0; i < pwr_seq_pkg::SYNC_W; i++) begin : g_bit
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                meta_r[i] <= pwr_seq_pkg::SYNC_RST[i];
                sync_r[i] <= pwr_seq_pkg::SYNC_RST[i];
            end else begin
                meta_r[i] <= pins.raw[i];
                sync_r[i] <= meta_r[i];
            end
        end
    end

    assign pins.synced = sync_r;

endmodule

`default_nettype wire

// File: hdl/power_boot_seq.sv
// Purpose: Module power, reset and boot-source sequencer facing the carrier
// Assumes: All carrier inputs asynchronous; suspend_req synchronous to sys_clk
// Notes:   Function

`timescale 1ns/1ps
`default_nettype none

module power_boot_seq #(
    parameter logic [29:0] HOLD_CYCLES = 30'(pwr_seq_pkg::HOLD_CYCLES_L)
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       main_rail_present,
    input  wire logic       input_power_fault_n,
    input  wire logic       external_reset_request_n,
    input  wire logic       power_button_n,
    input  wire logic       recovery_force_n,
    input  wire logic [2:0] boot_select_n,
    input  wire logic       suspend_req,
    output logic            core_power_enable,
    output logic            carrier_supply_enable,
    output logic            carrier_standby_n,
    output logic            module_reset_out_n,
    output logic [2:0]      boot_source,
    output logic            usb_port_zero_download_en,
    output logic            powered_off
);

    // ****************************************
    // Input synchronisation
    // ****************************************
    carrier_pins_if pins ();

    // Raw pin bundle into the synchroniser
    assign pins.raw = {main_rail_present, boot_select_n, recovery_force_n,
                       power_button_n, external_reset_request_n,
                       input_power_fault_n};

    pin_sync u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pins    (pins.sync_side)
    );

    logic       fault_n_s;
    logic       ext_rst_n_s;
    logic       button_n_s;
    logic       recov_n_s;
    logic [2:0] strap_s;
    logic       rail_s;

    // Synced views
    assign fault_n_s   = pins.synced[pwr_seq_pkg::IDX_FAULT];
    assign ext_rst_n_s = pins.synced[pwr_seq_pkg::IDX_EXTRST];
    assign button_n_s  = pins.synced[pwr_seq_pkg::IDX_BUTTON];
    assign recov_n_s   = pins.synced[pwr_seq_pkg::IDX_RECOV];
    assign strap_s     = pins.synced[pwr_seq_pkg::IDX_STRAP +: 3];
    assign rail_s      = pins.synced[pwr_seq_pkg::IDX_RAIL];

    // ****************************************
    // Counters
    // ****************************************
    pwr_seq_pkg::state_t      state_r;
    pwr_seq_pkg::state_t      state_nxt;
    logic [11:0]              settle_cnt_r;
    logic [29:0]              hold_cnt_r;
    logic                     settle_done;
    logic                     long_press;
    logic                     power_ok;
    logic                     armed_r;

    assign settle_done = settle_cnt_r == 12'(pwr_seq_pkg::SETTLE_CYCLES - 1);
    assign long_press  = hold_cnt_r == HOLD_CYCLES;
    assign power_ok    = rail_s && fault_n_s;

    // Settling time while carrier power comes up
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            settle_cnt_r <= 12'h000;
        end else if (state_r != pwr_seq_pkg::ST_CARRIER_UP) begin
            settle_cnt_r <= 12'h000;
        end else if (!settle_done) begin
            settle_cnt_r <= settle_cnt_r + 12'h001;
        end
    end

    // Button hold time, restarts on release and saturates
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hold_cnt_r <= 30'h00000000;
        end else if (button_n_s) begin
            hold_cnt_r <= 30'h00000000;
        end else if (!long_press) begin
            hold_cnt_r <= hold_cnt_r + 30'h00000001;
        end
    end

    // Button must be seen released before it can wake from power-off
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            armed_r <= 1'b0;
        end else if (state_r != pwr_seq_pkg::ST_HALT) begin
            armed_r <= 1'b0;
        end else if (button_n_s) begin
            armed_r <= 1'b1;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    // Next state; fault wins over everything else, long press over all but ST_OFF and ST_HALT
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            pwr_seq_pkg::ST_OFF: begin
                if (power_ok) begin
                    state_nxt = pwr_seq_pkg::ST_CARRIER_UP;
                end
            end
            pwr_seq_pkg::ST_CARRIER_UP: begin
                if (settle_done && ext_rst_n_s) begin
                    state_nxt = pwr_seq_pkg::ST_RUN;
                end
            end
            pwr_seq_pkg::ST_RUN: begin
                if (!ext_rst_n_s) begin
                    state_nxt = pwr_seq_pkg::ST_CARRIER_UP;
                end else if (suspend_req) begin
                    state_nxt = pwr_seq_pkg::ST_SUSPEND;
                end
            end
            pwr_seq_pkg::ST_SUSPEND: begin
                if (!ext_rst_n_s) begin
                    state_nxt = pwr_seq_pkg::ST_CARRIER_UP;
                end else if (!button_n_s) begin
                    state_nxt = pwr_seq_pkg::ST_RUN;
                end
            end
            pwr_seq_pkg::ST_HALT: begin
                if (armed_r && !button_n_s) begin
                    state_nxt = pwr_seq_pkg::ST_CARRIER_UP;
                end
            end
            default: begin
                state_nxt = pwr_seq_pkg::ST_OFF;
            end
        endcase
        if (!power_ok) begin
            state_nxt = pwr_seq_pkg::ST_OFF;
        end else if (long_press && state_r != pwr_seq_pkg::ST_HALT
                     && state_r != pwr_seq_pkg::ST_OFF) begin
            state_nxt = pwr_seq_pkg::ST_HALT;
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= pwr_seq_pkg::ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************
    // Power and reset outputs
    // ****************************************
    // Outputs registered from the next state so they track state_r
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            carrier_supply_enable <= 1'b0;
            carrier_standby_n     <= 1'b0;
            core_power_enable     <= 1'b0;
            module_reset_out_n    <= 1'b0;
            powered_off           <= 1'b1;
        end else begin
            carrier_supply_enable <= state_nxt == pwr_seq_pkg::ST_CARRIER_UP
                                  || state_nxt == pwr_seq_pkg::ST_RUN
                                  || state_nxt == pwr_seq_pkg::ST_SUSPEND;
            carrier_standby_n     <= state_nxt == pwr_seq_pkg::ST_CARRIER_UP
                                  || state_nxt == pwr_seq_pkg::ST_RUN;
            core_power_enable     <= state_nxt == pwr_seq_pkg::ST_CARRIER_UP
                                  || state_nxt == pwr_seq_pkg::ST_RUN;
            module_reset_out_n    <= state_nxt == pwr_seq_pkg::ST_RUN
                                  || state_nxt == pwr_seq_pkg::ST_SUSPEND;
            powered_off           <= state_nxt == pwr_seq_pkg::ST_OFF
                                  || state_nxt == pwr_seq_pkg::ST_HALT;
        end
    end

    // ****************************************
    // Boot source latch
    // ****************************************
    logic                    boot_take;
    pwr_seq_pkg::boot_src_t  boot_sel_nxt;
    pwr_seq_pkg::boot_src_t  boot_src_r;

    assign boot_take = state_r == pwr_seq_pkg::ST_CARRIER_UP
                    && state_nxt == pwr_seq_pkg::ST_RUN;

    // Recovery pin overrides the straps
    always_comb begin
        if (!recov_n_s) begin
            boot_sel_nxt = pwr_seq_pkg::BOOT_DL;
        end else begin
            boot_sel_nxt = pwr_seq_pkg::strap_decode(strap_s);
        end
    end

    // Sampled once per reset release, held until the next
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            boot_src_r <= pwr_seq_pkg::BOOT_FUSE;
        end else if (boot_take) begin
            boot_src_r <= boot_sel_nxt;
        end
    end

    // Download port enable follows the latched source while in ST_RUN
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            usb_port_zero_download_en <= 1'b0;
        end else begin
            usb_port_zero_download_en <= state_nxt == pwr_seq_pkg::ST_RUN
                && (boot_take ? boot_sel_nxt : boot_src_r)
                   == pwr_seq_pkg::BOOT_DL;
        end
    end

    assign boot_source = boot_src_r;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_pwr_before_rst;
        $rose(module_reset_out_n) |->
            $past(carrier_supply_enable) && $past(carrier_standby_n);
    endproperty
    a_pwr_before_rst: assert property (p_pwr_before_rst)
        else $error("reset released before carrier power");

    property p_settle_len;
        $rose(module_reset_out_n) |->
            $past(settle_cnt_r) == 12'(pwr_seq_pkg::SETTLE_CYCLES - 1);
    endproperty
    a_settle_len: assert property (p_settle_len)
        else $error("reset released before settling");

    property p_fault_off;
        !fault_n_s |=> !carrier_supply_enable && !core_power_enable;
    endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("power on during input fault");

    property p_ext_rst;
        !ext_rst_n_s |=> !module_reset_out_n;
    endproperty
    a_ext_rst: assert property (p_ext_rst)
        else $error("external reset did not hold reset");

    property p_hold_boot;
        !ext_rst_n_s ##1 !ext_rst_n_s |-> !$rose(module_reset_out_n);
    endproperty
    a_hold_boot: assert property (p_hold_boot)
        else $error("boot proceeded under reset request");

    property p_strap_decode;
        $rose(module_reset_out_n) && $past(recov_n_s) |->
            boot_src_r == pwr_seq_pkg::strap_decode($past(strap_s));
    endproperty
    a_strap_decode: assert property (p_strap_decode)
        else $error("wrong boot source from straps");

    property p_recov;
        $rose(module_reset_out_n) && !$past(recov_n_s) |->
            boot_src_r == pwr_seq_pkg::BOOT_DL;
    endproperty
    a_recov: assert property (p_recov)
        else $error("recovery pin ignored");

    property p_usb_dl;
        usb_port_zero_download_en |->
            boot_src_r == pwr_seq_pkg::BOOT_DL && state_r == pwr_seq_pkg::ST_RUN;
    endproperty
    a_usb_dl: assert property (p_usb_dl)
        else $error("download port enabled outside download");

    property p_long_press;
        long_press && power_ok && module_reset_out_n |=> powered_off;
    endproperty
    a_long_press: assert property (p_long_press)
        else $error("long press did not power off");

    property p_hold_restart;
        button_n_s |=> hold_cnt_r == 30'h00000000;
    endproperty
    a_hold_restart: assert property (p_hold_restart)
        else $error("hold counter not restarted");

    property p_wake;
        state_r == pwr_seq_pkg::ST_SUSPEND && !button_n_s && ext_rst_n_s
            && power_ok && !long_press |=> carrier_standby_n ##1 carrier_standby_n;
    endproperty
    a_wake: assert property (p_wake)
        else $error("button did not wake");

    property p_standby;
        !carrier_standby_n && carrier_supply_enable |->
            state_r == pwr_seq_pkg::ST_SUSPEND;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby low outside suspend");

    property p_supply;
        carrier_supply_enable == !powered_off;
    endproperty
    a_supply: assert property (p_supply)
        else $error("supply enable disagrees with power state");

    property p_boot_stable;
        module_reset_out_n && $past(module_reset_out_n) |-> $stable(boot_src_r);
    endproperty
    a_boot_stable: assert property (p_boot_stable)
        else $error("boot source changed while booted");

    c_boot: cover property ($rose(module_reset_out_n));
    c_suspend_wake: cover property (
        state_r == pwr_seq_pkg::ST_SUSPEND ##1 state_r == pwr_seq_pkg::ST_RUN);
    c_halt: cover property ($rose(powered_off) && rail_s);
    c_download: cover property ($rose(usb_port_zero_download_en));

endmodule

`default_nettype wire

// File: tb/carrier_board_model.sv
// Purpose: Carrier board side: input rail, fault line, reset request, button, straps
// Assumes: Commands from the bench change just after a sys_clk rising edge
// Notes:   Fault line held low until the rail has been stable for STABLE cycles

`timescale 1ns/1ps
`default_nettype none

module carrier_board_model #(
    parameter int STABLE = 8
) (
    input  wire logic       sys_clk,
    input  wire logic       power_on,
    input  wire logic       hold_reset,
    input  wire logic       press,
    input  wire logic       recover,
    input  wire logic [2:0] straps,
    output var logic        main_rail_present = 1'b0,
    output var logic        input_power_fault_n = 1'b0,
    output var logic        external_reset_request_n = 1'b1,
    output var logic        power_button_n = 1'b1,
    output var logic        recovery_force_n = 1'b1,
    output var logic [2:0]  boot_select_n = 3'h7
);
    logic [7:0] stable_r = 8'h00;

    // ****************************************
    // Pin drivers
    // ****************************************
    // Rail, fault release after settling, level pins
    always @(posedge sys_clk) begin
        main_rail_present <= power_on;
        if (!main_rail_present) begin
            stable_r <= 8'h00;
        end else if (stable_r != 8'(STABLE)) begin
            stable_r <= stable_r + 8'h01;
        end
        input_power_fault_n      <= main_rail_present && (stable_r == 8'(STABLE));
        external_reset_request_n <= !hold_reset;
        power_button_n           <= !press;
        recovery_force_n         <= !recover;
        boot_select_n            <= straps;
    end
endmodule

`default_nettype wire

// File: tb/module_power_boot_sequencer_tb_top.sv
// Purpose: Self-checking bench for the power, reset and boot sequencer
// Assumes: Short hold count parameter; settling count from the package
// Notes:   Boot source re-latched through external reset requests

`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

module module_power_boot_sequencer_tb_top;
    localparam logic [29:0] HOLD = 30'h32;

    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic       power_on = 1'b0;
    logic       hold_reset = 1'b0;
    logic       press = 1'b0;
    logic       recover = 1'b0;
    logic [2:0] straps = 3'h7;
    logic       suspend_req = 1'b0;
    logic       rail, fault_n, ext_n, button_n, recov_n;
    logic [2:0] sel_n;
    logic       core_en, supply, standby_n, reset_out_n, usb_dl, off;
    logic [2:0] boot_source;
    int         n_errors = 0;
    int         samples_checked = 0;
    int         cnt;
    logic [2:0] strap_tab [6] = '{3'h7, 3'h1, 3'h4, 3'h5, 3'h6, 3'h0};
    logic [2:0] src_tab   [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};

    carrier_board_model partner (
        .sys_clk                  (sys_clk),
        .power_on                 (power_on),
        .hold_reset               (hold_reset),
        .press                    (press),
        .recover                  (recover),
        .straps                   (straps),
        .main_rail_present        (rail),
        .input_power_fault_n      (fault_n),
        .external_reset_request_n (ext_n),
        .power_button_n           (button_n),
        .recovery_force_n         (recov_n),
        .boot_select_n            (sel_n)
    );

    power_boot_seq #(.HOLD_CYCLES(HOLD)) uut (
        .sys_clk                   (sys_clk),
        .rst                       (rst),
        .main_rail_present         (rail),
        .input_power_fault_n       (fault_n),
        .external_reset_request_n  (ext_n),
        .power_button_n            (button_n),
        .recovery_force_n          (recov_n),
        .boot_select_n             (sel_n),
        .suspend_req               (suspend_req),
        .core_power_enable         (core_en),
        .carrier_supply_enable     (supply),
        .carrier_standby_n         (standby_n),
        .module_reset_out_n        (reset_out_n),
        .boot_source               (boot_source),
        .usb_port_zero_download_en (usb_dl),
        .powered_off               (off)
    );

    // ****************************************
    // Clock and helpers
    // ****************************************
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Count cycles until reset output releases, bounded
    task automatic wait_release(input int lim);
        cnt = 0;
        while (reset_out_n !== 1'b1 && cnt < lim) begin
            tick(1);
            cnt++;
        end
    endtask

    // Hold a reset request, change straps, release and check the latched source
    task automatic relatch(input logic [2:0] s, input logic rc, input logic [2:0] exp);
        hold_reset = 1'b1;
        straps     = s;
        recover    = rc;
        tick(5);
        `CHK("reset_out_n in request", 1'b0, reset_out_n)
        `CHK("supply in request", 1'b1, supply)
        tick(2100);
        `CHK("reset_out_n held off", 1'b0, reset_out_n)
        hold_reset = 1'b0;
        wait_release(10);
        `CHK("boot_source", exp, boot_source)
        `CHK("usb download", (exp == 3'h4), usb_dl)
        straps  = 3'h0;
        recover = 1'b0;
        tick(4);
        `CHK("boot_source kept", exp, boot_source)
    endtask

    task automatic tally_and_finish;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        tick(3);
        rst = 1'b0;
        `CHK("off at reset", 1'b1, off)
        `CHK("supply at reset", 1'b0, supply)
        power_on = 1'b1;
        cnt = 0;
        while (supply !== 1'b1 && cnt < 30) begin
            tick(1);
            cnt++;
        end
        `CHK("supply up", 1'b1, supply)
        `CHK("standby_n up", 1'b1, standby_n)
        `CHK("reset_out_n low while settling", 1'b0, reset_out_n)
        `CHK("core power", 1'b1, core_en)
        wait_release(3000);
        `CHK("settle cycles", pwr_seq_pkg::SETTLE_CYCLES, cnt)
        // Every strap code and one unlisted pattern, then recovery
        for (int i = 0; i < 6; i++) begin
            relatch(strap_tab[i], 1'b0, src_tab[i]);
        end
        relatch(3'h1, 1'b1, 3'h4);
        // Suspend and wake
        suspend_req = 1'b1;
        tick(2);
        `CHK("standby_n in suspend", 1'b0, standby_n)
        `CHK("core off in suspend", 1'b0, core_en)
        `CHK("reset_out_n in suspend", 1'b1, reset_out_n)
        suspend_req = 1'b0;
        press = 1'b1;
        tick(6);
        `CHK("standby_n after wake", 1'b1, standby_n)
        press = 1'b0;
        tick(6);
        // Hold counter restarts on release
        press = 1'b1;
        tick(40);
        press = 1'b0;
        tick(5);
        press = 1'b1;
        tick(40);
        `CHK("no power off on split press", 1'b0, off)
        press = 1'b0;
        tick(6);
        press = 1'b1;
        tick(int'(HOLD) - 5);
        `CHK("still on before hold ends", 1'b0, off)
        tick(10);
        `CHK("powered off after hold", 1'b1, off)
        `CHK("supply off after hold", 1'b0, supply)
        `CHK("reset_out_n off after hold", 1'b0, reset_out_n)
        press = 1'b0;
        tick(6);
        press = 1'b1;
        tick(6);
        press = 1'b0;
        `CHK("supply after new press", 1'b1, supply)
        // Input fault removes power
        power_on = 1'b0;
        tick(6);
        `CHK("off on fault", 1'b1, off)
        `CHK("supply on fault", 1'b0, supply)
        power_on = 1'b1;
        tick(30);
        `CHK("supply after fault clears", 1'b1, supply)
        tally_and_finish();
    end

    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        #250000;
        n_errors++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
